// [dram_host_pkg.sv]
// Purpose: Shared constants and types for the page-mode memory module controller
// Assumes: 40 MHz mclk, module pins sampled synchronously
// Notes:   Times are kept in their own units; cycle counts derive from them
package dram_host_pkg;
    localparam int unsigned CLK_MHZ         = 40;
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned ADDR_W          = 20;
    localparam int unsigned HALF_W          = 10;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned ROWS            = 1024;
    localparam int unsigned WAKE_CYCLES     = 8;
    // Power-up pause and refresh spacing
    localparam int unsigned PWRUP_US        = 100;
    localparam int unsigned PWRUP_CYC       = PWRUP_US * CLK_MHZ;
    localparam int unsigned REF_MS          = 16;
    localparam int unsigned REF_LP_MS       = 128;
    localparam int unsigned REF_INT_NS      = REF_MS * 1000000 / ROWS;
    localparam int unsigned REF_INT_CYC     = REF_INT_NS / CLK_PERIOD_NS;
    localparam int unsigned REF_LP_US       = 125;
    localparam int unsigned REF_LP_CYC      = REF_LP_US * CLK_MHZ;
    // Pin timing floors, one figure each
    localparam int unsigned T_RP_NS         = 60;
    localparam int unsigned T_RAS_NS        = 80;
    localparam int unsigned T_CAS_NS        = 20;
    localparam int unsigned T_CP_NS         = 10;
    localparam int unsigned T_RCD_NS        = 20;
    localparam int unsigned T_CSR_NS        = 10;
    localparam int unsigned T_RAC_NS        = 80;
    localparam int unsigned T_RP_CYC        = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned T_RAS_CYC       = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned T_CAS_CYC       = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned T_CP_CYC        = (T_CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned T_RCD_CYC       = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned T_CSR_CYC       = (T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned T_RAC_CYC       = (T_RAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 16;

    // Request from user side
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_t;

    // Pins toward the module
    typedef struct packed {
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [HALF_W-1:0] address_lines;
        logic [DATA_W-1:0] data_out;
        logic              data_oe;
    } pins_t;
endpackage : dram_host_pkg

// [refresh_timer.sv]
// Purpose: Refresh request pacing for the memory controller
// Assumes: Single mclk domain, synchronous active-high reset
// Notes:   Emits a one-cycle tick each refresh interval
`timescale 1ns/100ps
module refresh_timer #(
    parameter int unsigned NORMAL_CYC = dram_host_pkg::REF_INT_CYC,
    parameter int unsigned LOWPWR_CYC = dram_host_pkg::REF_LP_CYC
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic low_power,
    output logic      tick
);
    logic [dram_host_pkg::CNT_W-1:0] cnt_r;
    logic [dram_host_pkg::CNT_W-1:0] cnt_nxt;
    logic                            tick_nxt;

    // Count down; the reload picks the interval so a mode change takes effect next period
    always_comb begin
        tick_nxt = 1'b0;
        if (cnt_r == '0) begin
            tick_nxt = 1'b1;
            cnt_nxt  = low_power ? dram_host_pkg::CNT_W'(LOWPWR_CYC - 1)
                                 : dram_host_pkg::CNT_W'(NORMAL_CYC - 1);
        end else begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule : refresh_timer

// [dram_host.sv]
// Purpose: Controller that drives a 1M x 8 page-mode memory module over its strobe pins
// Assumes: Pins sampled on mclk; module data pins resolved by the testbench from data_oe
// Notes:   Refresh is counter-based between accesses; page mode keeps the row open
`timescale 1ns/100ps
module dram_host #(
    parameter int unsigned PWRUP_CYC = dram_host_pkg::PWRUP_CYC
) (
    input  wire logic                              mclk,
    input  wire logic                              rst,
    input  wire logic                              low_power,
    input  wire logic                              req_valid,
    input  wire dram_host_pkg::req_t               req,
    output logic                                   req_ready,
    output logic                                   rd_valid,
    output logic [dram_host_pkg::DATA_W-1:0]       rd_data,
    output logic                                   init_done,
    input  wire logic [dram_host_pkg::DATA_W-1:0]  data_in,
    output dram_host_pkg::pins_t                   pins
);
    typedef enum logic [3:0] {
        S_PWRUP, S_WAKE_LO, S_WAKE_HI, S_IDLE, S_ROW, S_RCD, S_COL, S_CAS_HI,
        S_PRE, S_CBR_CAS, S_CBR_RAS
    } state_t;

    state_t                              state_r, state_nxt;
    logic [dram_host_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;
    logic [3:0]                          wake_r, wake_nxt;
    logic                                ref_pend_r, ref_pend_nxt;
    logic                                tick;
    logic [dram_host_pkg::HALF_W-1:0]    row_r, row_nxt;
    logic                                wr_r, wr_nxt;
    dram_host_pkg::req_t                 cur_r, cur_nxt;
    dram_host_pkg::pins_t                pins_nxt;
    logic                                ready_nxt, rdv_nxt, done_nxt;
    logic [dram_host_pkg::DATA_W-1:0]    rdd_nxt;

    // Same row test used for page hits
    function automatic logic same_row(input logic [dram_host_pkg::ADDR_W-1:0] a,
                                      input logic [dram_host_pkg::HALF_W-1:0] r);
        return a[dram_host_pkg::ADDR_W-1 -: dram_host_pkg::HALF_W] == r;
    endfunction : same_row

    refresh_timer u_timer (
        .mclk      (mclk),
        .rst       (rst),
        .low_power (low_power),
        .tick      (tick)
    );

    // Sequencer: refresh wins over a new access only at a cycle boundary
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        wake_nxt     = wake_r;
        ref_pend_nxt = ref_pend_r | tick;
        row_nxt      = row_r;
        wr_nxt       = wr_r;
        cur_nxt      = cur_r;
        pins_nxt     = pins;
        ready_nxt    = 1'b0;
        rdv_nxt      = 1'b0;
        rdd_nxt      = rd_data;
        done_nxt     = init_done;
        unique case (state_r)
            S_PWRUP: begin
                if (cnt_r == '0) begin
                    state_nxt = S_WAKE_LO;
                    cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_RAS_CYC);
                    pins_nxt.ras_n = 1'b0;
                end
            end
            S_WAKE_LO: if (cnt_r == '0) begin
                pins_nxt.ras_n = 1'b1;
                wake_nxt  = wake_r + 1'b1;
                cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_RP_CYC);
                state_nxt = S_WAKE_HI;
            end
            S_WAKE_HI: if (cnt_r == '0) begin
                if (wake_r == 4'(dram_host_pkg::WAKE_CYCLES)) begin
                    // Wake rows count as refresh; drop a tick that came during the pause
                    state_nxt    = S_IDLE;
                    done_nxt     = 1'b1;
                    ref_pend_nxt = 1'b0;
                    ready_nxt    = ~tick;
                end else begin
                    pins_nxt.ras_n = 1'b0;
                    cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_RAS_CYC);
                    state_nxt = S_WAKE_LO;
                end
            end
            S_IDLE: begin
                // Ready must not promise a take that a pending refresh would pre-empt
                ready_nxt = ~ref_pend_nxt;
                // Hidden refresh is never used: counter refresh only after an access ends
                if (ref_pend_r) begin
                    ready_nxt      = 1'b0;
                    ref_pend_nxt   = 1'b0;
                    pins_nxt.cas_n = 1'b0;
                    pins_nxt.we_n  = 1'b1;
                    pins_nxt.data_oe = 1'b0;
                    cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_CSR_CYC);
                    state_nxt = S_CBR_CAS;
                end else if (req_valid && req_ready) begin
                    ready_nxt = 1'b0;
                    cur_nxt   = req;
                    row_nxt   = req.addr[dram_host_pkg::ADDR_W-1 -: dram_host_pkg::HALF_W];
                    pins_nxt.address_lines = row_nxt;
                    state_nxt = S_ROW;
                end
            end
            S_ROW: begin
                pins_nxt.ras_n = 1'b0;
                cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_RCD_CYC);
                state_nxt = S_RCD;
            end
            S_RCD: if (cnt_r == '0) begin
                // Write-enable and data settle before the column strobe: early write only
                pins_nxt.address_lines = cur_r.addr[dram_host_pkg::HALF_W-1:0];
                pins_nxt.we_n     = ~cur_r.write;
                pins_nxt.data_out = cur_r.wdata;
                pins_nxt.data_oe  = cur_r.write;
                wr_nxt    = cur_r.write;
                state_nxt = S_COL;
            end
            S_COL: begin
                pins_nxt.cas_n = 1'b0;
                cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_RAC_CYC);
                state_nxt = S_CAS_HI;
            end
            S_CAS_HI: if (cnt_r == '0) begin
                if (!wr_r) begin
                    rdv_nxt = 1'b1;
                    rdd_nxt = data_in;
                end
                pins_nxt.cas_n   = 1'b1;
                pins_nxt.data_oe = 1'b0;
                // Page hit continues with another column; otherwise close the row
                if (req_valid && !ref_pend_r && same_row(req.addr, row_r)) begin
                    cur_nxt   = req;
                    ready_nxt = 1'b0;
                    cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_CP_CYC);
                    state_nxt = S_RCD;
                end else begin
                    pins_nxt.ras_n = 1'b1;
                    cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_RP_CYC);
                    state_nxt = S_PRE;
                end
            end
            S_PRE: if (cnt_r == '0) begin
                pins_nxt.we_n = 1'b1;
                ready_nxt = ~ref_pend_nxt;
                state_nxt = S_IDLE;
            end
            S_CBR_CAS: if (cnt_r == '0) begin
                pins_nxt.ras_n = 1'b0;
                cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_RAS_CYC);
                state_nxt = S_CBR_RAS;
            end
            S_CBR_RAS: if (cnt_r == '0) begin
                pins_nxt.ras_n = 1'b1;
                pins_nxt.cas_n = 1'b1;
                cnt_nxt   = dram_host_pkg::CNT_W'(dram_host_pkg::T_RP_CYC);
                state_nxt = S_PRE;
            end
            default: state_nxt = S_PWRUP;
        endcase
    end

    // State registers; pins idle with both strobes high and data released
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r    <= S_PWRUP;
            cnt_r      <= dram_host_pkg::CNT_W'(PWRUP_CYC);
            wake_r     <= 4'h0;
            ref_pend_r <= 1'b0;
            row_r      <= '0;
            wr_r       <= 1'b0;
            cur_r      <= '0;
            pins       <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, address_lines: '0,
                            data_out: '0, data_oe: 1'b0};
            req_ready  <= 1'b0;
            rd_valid   <= 1'b0;
            rd_data    <= '0;
            init_done  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            wake_r     <= wake_nxt;
            ref_pend_r <= ref_pend_nxt;
            row_r      <= row_nxt;
            wr_r       <= wr_nxt;
            cur_r      <= cur_nxt;
            pins       <= pins_nxt;
            req_ready  <= ready_nxt;
            rd_valid   <= rdv_nxt;
            rd_data    <= rdd_nxt;
            init_done  <= done_nxt;
        end
    end

    // Checks on pin behaviour
    property p_end_both_high;
        @(posedge mclk) disable iff (rst)
        (state_r == S_IDLE) |-> (pins.ras_n && pins.cas_n);
    endproperty
    a_end_both_high: assert property (p_end_both_high) else $error("strobes not high in idle");
    property p_write_early;
        @(posedge mclk) disable iff (rst)
        $fell(pins.cas_n) && !pins.ras_n && wr_r |-> !pins.we_n && pins.data_oe;
    endproperty
    a_write_early: assert property (p_write_early) else $error("write not early");
    property p_read_we;
        @(posedge mclk) disable iff (rst)
        $fell(pins.cas_n) && !pins.ras_n && !wr_r |-> pins.we_n && !pins.data_oe;
    endproperty
    a_read_we: assert property (p_read_we) else $error("read with write-enable low");
    property p_cbr_order;
        @(posedge mclk) disable iff (rst)
        $fell(pins.ras_n) && !pins.cas_n |-> pins.we_n && !pins.data_oe;
    endproperty
    a_cbr_order: assert property (p_cbr_order) else $error("bad counter refresh");
    property p_cas_after_ras;
        @(posedge mclk) disable iff (rst)
        $fell(pins.cas_n) && (state_r == S_CAS_HI) |-> !pins.ras_n;
    endproperty
    a_cas_after_ras: assert property (p_cas_after_ras) else $error("column before row");
    property p_read_hold;
        @(posedge mclk) disable iff (rst)
        !wr_r && !pins.cas_n |=> pins.we_n;
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read hold violated");
    property p_no_access_early;
        @(posedge mclk) disable iff (rst)
        !init_done |-> pins.cas_n && !req_ready;
    endproperty
    a_no_access_early: assert property (p_no_access_early) else $error("access before wake-up");
    property p_ref_idle;
        @(posedge mclk) disable iff (rst)
        (state_r == S_IDLE) && ref_pend_r |=> !pins.cas_n ##[1:2] !pins.ras_n;
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("refresh not started");
    c_read:  cover property (@(posedge mclk) disable iff (rst) rd_valid);
    c_write: cover property (@(posedge mclk) disable iff (rst) $fell(pins.cas_n) && wr_r);
    c_cbr:   cover property (@(posedge mclk) disable iff (rst) state_r == S_CBR_RAS);
    c_page:  cover property (@(posedge mclk) disable iff (rst) state_r == S_CAS_HI ##1 state_r == S_RCD);
endmodule : dram_host

// [dram_module_model.sv]
// Purpose: Behavioural 1M x 8 page-mode memory module facing the host pins
// Assumes: Strobes active low; precharge floor from the shared package
// Notes:   Slips on the pins are counted in viol for the bench to read
`timescale 1ns/100ps
module dram_module_model (
    input  wire dram_host_pkg::pins_t pins,
    input  wire logic [7:0]           dq_in,
    input  wire logic                 slow,
    output logic [7:0]                dq,
    output logic                      drv
);
    logic [7:0] mem [int];
    logic [9:0] row = '0, col = '0, ref_row = '0;
    logic [7:0] dout = '0, last = 8'hA5, junk = '0;
    logic       ok = 1'b0, have_col = 1'b0;
    int         ras_falls = 0, row_only = 0, cbr_count = 0, page_hits = 0, viol = 0;
    realtime    t_rise = 0;
    initial drv = 1'b0;
    // Released pins never keep the last byte, so a late sample cannot pass by luck
    always #9 junk = junk + 8'h3B;
    assign dq = drv ? (ok ? dout : junk) : ~last;
    // Row strobe fall opens a row, or refreshes from the counter when column is low
    always @(negedge pins.ras_n) begin
        ras_falls++;
        have_col = 1'b0;
        if ($realtime - t_rise < dram_host_pkg::T_RP_NS) viol++;
        if (pins.cas_n) begin
            row = pins.address_lines;
            row_only++;
        end else begin
            cbr_count++;
            ref_row = ref_row + 10'h001;
        end
    end
    always @(posedge pins.ras_n) t_rise = $realtime;
    // Column fall in an open row is one access; slow mode delays the data
    always @(negedge pins.cas_n) begin
        if (!pins.ras_n) begin
            if (have_col) page_hits++;
            have_col = 1'b1;
            col = pins.address_lines;
            if (!pins.we_n) begin
                mem[{row, col}] = dq_in;
            end else begin
                dout = mem.exists({row, col}) ? mem[{row, col}] : 8'h00;
                drv = 1'b1;
                ok = 1'b0;
                #(slow ? 100 : 20) ok = 1'b1;
            end
        end
    end
    // Write-enable falling inside a live column cycle is a late write
    always @(negedge pins.we_n) begin
        if (!pins.cas_n && !pins.ras_n) begin
            viol++;
            mem[{row, col}] = dq_in;
        end
    end
    // Column rise releases the data pins
    always @(posedge pins.cas_n) begin
        if (drv && ok) last = dout;
        drv = 1'b0;
    end
    // Both sides driving the data lines at once
    always @(pins.data_oe or drv) begin
        if (pins.data_oe && drv) viol++;
    end
endmodule : dram_module_model

// [tb.sv]
// Purpose: Self-checking bench for the page-mode memory module controller
// Assumes: Module model on the far side; short power-up pause to keep runs brief
// Notes:   Reads are queued at the take and matched as rd_valid pulses arrive
`timescale 1ns/100ps
module tb;
    localparam int unsigned PWR = 20;
    logic                 mclk, rst, low_power, req_valid, req_ready, rd_valid, init_done, slow, dev_drv;
    dram_host_pkg::req_t  req;
    dram_host_pkg::pins_t pins;
    logic [7:0]           rd_data, data_in, dev_dq;
    logic [7:0]           refm [int];
    logic [7:0]           expq [$];
    logic [19:0]          a;
    logic [19:0]          addrs [$];
    int                   err_total = 0, n_compared = 0, seed, c0;

    dram_host #(.PWRUP_CYC(PWR)) dram_host_i (.mclk(mclk), .rst(rst), .low_power(low_power),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .init_done(init_done), .data_in(data_in), .pins(pins));
    dram_module_model dram_module_model_i (.pins(pins), .dq_in(data_in), .slow(slow), .dq(dev_dq),
        .drv(dev_drv));
    // Host wins the wire only while it enables its drivers
    assign data_in = pins.data_oe ? pins.data_out : dev_dq;
    always #12.5 mclk = ~mclk;

    task automatic check_num(input int got, input int exp, input string msg);
        n_compared++;
        if (got != exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, msg, got, exp);
        end
    endtask : check_num
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check_byte
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : cyc
    task automatic idle(input int n);
        req_valid = 1'b0;
        cyc(n);
    endtask : idle
    // Taken when ready was up, or at a column end that leaves the row open
    task automatic issue(input logic w, input logic [19:0] ad, input logic [7:0] d);
        logic rdy_b, cas_b;
        int   n;
        req_valid = 1'b1;
        req = {w, ad, d};
        n = 0;
        do begin
            rdy_b = req_ready;
            cas_b = pins.cas_n;
            cyc(1);
            n++;
        end while (!(rdy_b === 1'b1 || (pins.cas_n === 1'b1 && cas_b === 1'b0 && pins.ras_n === 1'b0))
                   && n < 500);
        check_num(n < 500, 1, "request take");
        if (w)
            refm[ad] = d;
        else
            expq.push_back(refm[ad]);
    endtask : issue
    // Pause, then eight row-only wake cycles, then ready
    task automatic wait_init();
        int n, f0;
        f0 = dram_module_model_i.row_only;
        for (n = 0; pins.ras_n === 1'b1 && n < 5000; n++) cyc(1);
        check_num(n >= PWR, 1, "power-up pause");
        for (n = 0; init_done !== 1'b1 && n < 5000; n++) cyc(1);
        check_num(dram_module_model_i.row_only - f0, 8, "wake cycles");
        check_num(req_ready === 1'b1, 1, "ready after wake");
    endtask : wait_init

    // Each read answer is matched against the oldest expectation
    always @(negedge mclk) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0)
                check_num(1, 0, "unexpected read answer");
            else
                check_byte(rd_data, expq.pop_front(), "read data");
        end
    end

    // Hang guard, well beyond the planned run of about 20000 cycles
    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        low_power = 1'b0;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        seed = 82;
        cyc(10);
        rst = 1'b0;
        wait_init();
        $display("test wake-up done");
        // Random writes with boundary addresses, some read back at once
        for (int i = 0; i < 16; i++) begin
            a = (i == 0) ? 20'h00000 : (i == 1) ? 20'hFFFFF : 20'($random(seed));
            slow = 1'($random(seed));
            issue(1'b1, a, 8'($random(seed)));
            addrs.push_back(a);
            if (i % 3 == 0) issue(1'b0, a, 8'h00);
            if (i % 4 == 1) idle(7);
        end
        while (addrs.size() > 0) issue(1'b0, addrs.pop_back(), 8'h00);
        idle(30);
        check_num(expq.size(), 0, "reads drained");
        $display("test random access done");
        // Same row back to back keeps the row open
        a = 20'($random(seed));
        c0 = dram_module_model_i.page_hits;
        // Reads revisit the four columns just written
        for (int i = 0; i < 8; i++) issue(i < 4, {a[19:10], 10'((i % 4) * 37 + 3)}, 8'(8'hC3 ^ i));
        idle(30);
        check_num(dram_module_model_i.page_hits - c0 >= 6, 1, "page hits");
        $display("test page mode done");
        // Counter refresh pacing, normal then low power
        c0 = dram_module_model_i.cbr_count;
        idle(5 * dram_host_pkg::REF_INT_CYC);
        c0 = dram_module_model_i.cbr_count - c0;
        check_num(c0 >= 4 && c0 <= 6, 1, "refresh count");
        low_power = 1'b1;
        c0 = dram_module_model_i.cbr_count;
        idle(3 * dram_host_pkg::REF_LP_CYC);
        c0 = dram_module_model_i.cbr_count - c0;
        check_num(c0 >= 2 && c0 <= 4, 1, "low-power refresh count");
        low_power = 1'b0;
        $display("test refresh done");
        // Reset in mid-write, then a fresh wake-up
        issue(1'b1, 20'h12345, 8'h5A);
        idle(3);
        rst = 1'b1;
        idle(10);
        check_byte({2'b00, pins.ras_n, pins.cas_n, pins.we_n, pins.data_oe, req_ready, init_done}, 8'h38,
                   "reset pins");
        rst = 1'b0;
        wait_init();
        issue(1'b1, 20'hABCDE, 8'h3C);
        issue(1'b0, 20'hABCDE, 8'h00);
        idle(30);
        $display("test mid-run reset done");
        check_num(expq.size(), 0, "reads outstanding");
        check_num(dram_module_model_i.viol, 0, "pin protocol");
        close_out();
    end
endmodule : tb
